// ### rtl/fsd_pkg.sv
package fsd_pkg;

   localparam int RAW_W = 14;
   localparam int GAIN_W = 14;
   localparam int GAIN_FRAC = 11;
   localparam int OFS_W = 11;
   localparam int CLO_W = 10;
   localparam int CHI_W = 11;
   localparam int OUT_W = 11;
   localparam int MODE_W = 6;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int TC_W = 8;
   localparam int FILT_FRAC = 8;

   // parameter memory map, one word per address
   localparam logic [3:0] A_MODE = 4'h0;
   localparam logic [3:0] A_TC = 4'h1;
   localparam logic [3:0] A_QUADRATIC_TEMP_COEFFICIENT = 4'h2;
   localparam logic [3:0] A_GAIN = 4'h3;
   localparam logic [3:0] A_OFS = 4'h4;
   localparam logic [3:0] A_CLO = 4'h5;
   localparam logic [3:0] A_CHI = 4'h6;
   localparam logic [3:0] A_LOCK = 4'h7;
   localparam logic [3:0] A_RAW = 4'h8;
   localparam logic [3:0] A_TRIM0 = 4'h9;
   localparam logic [3:0] A_LAST = 4'hb;

   // mode fields
   localparam int RANGE_LSB = 0;
   localparam int FILT_LSB = 3;

   // reset values before the power-up load
   localparam logic [5:0] MODE_RST = 6'h00;
   localparam logic [13:0] GAIN_RST = 14'h0800;
   localparam logic [10:0] OFS_RST = 11'h000;
   localparam logic [9:0] CLO_RST = 10'h000;
   localparam logic [10:0] CHI_RST = 11'h7ff;

   localparam logic [2:0] F_80 = 3'h0;
   localparam logic [2:0] F_160 = 3'h1;
   localparam logic [2:0] F_500 = 3'h2;
   localparam logic [2:0] F_1K = 3'h3;

   function automatic logic [2:0] filt_shift(input logic [2:0] f);
      unique case (f)
         F_80: filt_shift = 3'h7;
         F_160: filt_shift = 3'h6;
         F_500: filt_shift = 3'h5;
         F_1K: filt_shift = 3'h4;
         default: filt_shift = 3'h3;
      endcase
   endfunction : filt_shift

   function automatic logic [13:0] raw_max(input logic [2:0] f);
      unique case (f)
         F_80: raw_max = 14'h0f7f;
         F_160: raw_max = 14'h07c1;
         F_500: raw_max = 14'h14aa;
         F_1K: raw_max = 14'h0a55;
         default: raw_max = 14'h05e7;
      endcase
   endfunction : raw_max

   function automatic logic [13:0] raw_min(input logic [2:0] f);
      unique case (f)
         F_80: raw_min = 14'h3080;
         F_160: raw_min = 14'h383f;
         F_500: raw_min = 14'h2b54;
         F_1K: raw_min = 14'h35aa;
         default: raw_min = 14'h3a18;
      endcase
   endfunction : raw_min

endpackage : fsd_pkg

// ### rtl/stream_if.sv
`timescale 1ns/1ps
interface stream_if #(parameter int W = 14);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : stream_if

// ### rtl/lp_filter.sv
`timescale 1ns/1ps
module lp_filter (
   input wire logic ref_clk, // clock
   input wire logic rst_n, // synchronised reset
   input wire logic [2:0] filt_sel, // cutoff code
   input wire logic in_valid, // converter sample strobe
   input wire logic [fsd_pkg::RAW_W-1:0] in_data, // signed sample
   output logic in_ready, // sample taken
   stream_if.src flt // filtered stream
);
   localparam int AW = fsd_pkg::RAW_W + fsd_pkg::FILT_FRAC + 2;
   logic signed [AW-1:0] acc_q;
   logic signed [AW-1:0] x_ext;
   logic signed [AW-1:0] step;
   logic signed [AW-1:0] y_full;
   logic signed [fsd_pkg::RAW_W-1:0] hi;
   logic signed [fsd_pkg::RAW_W-1:0] lo;
   logic signed [fsd_pkg::RAW_W-1:0] y_sat;
   logic v_q;
   logic [fsd_pkg::RAW_W-1:0] d_q;

   assign in_ready = !v_q || flt.ready;
   assign x_ext = AW'(signed'(in_data)) <<< fsd_pkg::FILT_FRAC;
   assign step = (x_ext - acc_q) >>> fsd_pkg::filt_shift(filt_sel);
   assign y_full = (acc_q + step) >>> fsd_pkg::FILT_FRAC;
   assign hi = signed'(fsd_pkg::raw_max(filt_sel));
   assign lo = signed'(fsd_pkg::raw_min(filt_sel));

   // span depends on cutoff setting
   always_comb
   begin
      if (y_full > AW'(hi))
         y_sat = hi;
      else if (y_full < AW'(lo))
         y_sat = lo;
      else
         y_sat = y_full[fsd_pkg::RAW_W-1:0];
   end

   // first-order low pass on every sample
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         acc_q <= '0;
      else if (in_valid && in_ready)
         acc_q <= acc_q + step;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         v_q <= 1'b0;
         d_q <= '0;
      end
      else if (in_ready)
      begin
         v_q <= in_valid;
         if (in_valid)
            d_q <= y_sat;
      end
   end

   assign flt.valid = v_q;
   assign flt.data = d_q;
endmodule : lp_filter

// ### rtl/skid_buffer.sv
`timescale 1ns/1ps
module skid_buffer #(
   parameter int W = 11,
   parameter int DEPTH = 2
) (
   input wire logic ref_clk, // clock
   input wire logic rst_n, // synchronised reset
   stream_if.snk wr, // filling side
   stream_if.src rd // draining side
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   assign wr.ready = (cnt_q != (PW+1)'(DEPTH));
   assign rd.valid = (cnt_q != '0);
   assign rd.data = mem[rp_q];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[wp_q] <= wr.data;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
         if (pop)
            rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : skid_buffer

// ### rtl/field_sensor_dsp_chain.sv
`timescale 1ns/1ps
module field_sensor_dsp_chain (
   input wire logic ref_clk, // 100 MHz clock
   input wire logic arst_n, // async reset, power-on
   input wire logic adc_valid, // converter sample strobe
   input wire logic [13:0] adc_data, // signed field sample
   output logic adc_ready, // sample accepted
   output logic [2:0] adc_range_sel, // converter range code
   output logic [7:0] adc_range_mt, // range magnitude in mT
   output logic [7:0] tc_lin, // linear temp coefficient
   output logic [7:0] tc_quad, // quadratic temp coefficient
   output logic [47:0] trim_bus, // factory trims to analog
   output logic dac_valid, // output code valid
   output logic [10:0] dac_data, // output code, 0..vdd
   input wire logic dac_ready, // converter takes code
   output logic analog_drive_en, // analog output stage on
   input wire logic comm_active, // supply modulation seen
   input wire logic sel_pin, // output pin selection level
   input wire logic cmd_valid, // decoded command strobe
   input wire logic cmd_write, // 1 write, 0 read
   input wire logic [3:0] cmd_addr, // parameter address
   input wire logic [15:0] cmd_wdata, // write data
   output logic resp_valid, // response pulse
   output logic resp_ok, // command carried out
   output logic [15:0] resp_data, // read data
   output logic nvm_req, // memory access request
   output logic nvm_we, // memory access is write
   output logic [3:0] nvm_addr, // memory address
   output logic [15:0] nvm_wdata, // memory write data
   input wire logic nvm_ack, // memory access done
   input wire logic [15:0] nvm_rdata, // memory read data
   output logic lock_active // parameters frozen
);
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10,
      ST_RESP = 2'b11
   } st_t;

   localparam int SW = 20;

   ////////////////////////////////////////////////////////////////////////
   // reset release and pin synchroniser
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [2:0] sel_sync_q;
   logic sel_q;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // selection level only counts once two late stages agree
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_sync_q <= 3'h0;
         sel_q <= 1'b0;
      end
      else
      begin
         sel_sync_q <= {sel_sync_q[1:0], sel_pin};
         if (sel_sync_q[2] == sel_sync_q[1])
            sel_q <= sel_sync_q[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // parameter shadow registers
   st_t st_q;
   logic [3:0] ld_addr_q;
   logic [5:0] mode_q;
   logic [7:0] tc_q;
   logic [7:0] quadratic_temp_coefficient_q;
   logic [13:0] gain_q;
   logic [10:0] ofs_q;
   logic [9:0] clo_q;
   logic [10:0] chi_q;
   logic lock_stored_q;
   logic lock_active_q;
   logic [15:0] trim_q [3];
   logic [13:0] raw_q;
   logic [3:0] cur_addr;
   logic [15:0] cur_data;
   logic upd;
   logic [3:0] op_addr_q;
   logic [15:0] op_wdata_q;
   logic op_write_q;
   logic op_ok_q;
   logic [15:0] op_rdata_q;

   assign upd = nvm_req && nvm_ack;
   assign cur_addr = nvm_addr;
   assign cur_data = (st_q == ST_LOAD) ? nvm_rdata : op_wdata_q;

   // shadow copy taken at power-up load and on accepted writes
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= fsd_pkg::MODE_RST;
         tc_q <= '0;
         quadratic_temp_coefficient_q <= '0;
         gain_q <= fsd_pkg::GAIN_RST;
         ofs_q <= fsd_pkg::OFS_RST;
         clo_q <= fsd_pkg::CLO_RST;
         chi_q <= fsd_pkg::CHI_RST;
         lock_stored_q <= 1'b0;
      end
      else if (upd && (st_q == ST_LOAD || op_write_q))
      begin
         unique case (cur_addr)
            fsd_pkg::A_MODE: mode_q <= cur_data[5:0];
            fsd_pkg::A_TC: tc_q <= cur_data[7:0];
            fsd_pkg::A_QUADRATIC_TEMP_COEFFICIENT: quadratic_temp_coefficient_q <= cur_data[7:0];
            fsd_pkg::A_GAIN: gain_q <= cur_data[13:0];
            fsd_pkg::A_OFS: ofs_q <= cur_data[10:0];
            fsd_pkg::A_CLO: clo_q <= cur_data[9:0];
            fsd_pkg::A_CHI: chi_q <= cur_data[10:0];
            // sticky: a zero never clears it
            fsd_pkg::A_LOCK: lock_stored_q <= lock_stored_q | cur_data[0];
            default: ;
         endcase
      end
   end

   // trims only ever come from the load sequence
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_trim
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
               trim_q[i] <= '0;
            else if (upd && st_q == ST_LOAD
                     && cur_addr == fsd_pkg::A_TRIM0 + 4'(i))
               trim_q[i] <= nvm_rdata;
         end
         assign trim_bus[16*i +: 16] = trim_q[i];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // load and command sequencer
   logic cmd_take;
   logic wr_allowed;

   // lock sampled only at the end of power-up load
   assign cmd_take = cmd_valid && sel_q && !lock_active_q;
   assign wr_allowed = (cmd_addr <= fsd_pkg::A_LOCK) && !lock_active_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= ST_LOAD;
         ld_addr_q <= '0;
         lock_active_q <= 1'b0;
         op_addr_q <= '0;
         op_wdata_q <= '0;
         op_write_q <= 1'b0;
         op_ok_q <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            ST_LOAD:
            begin
               if (upd)
               begin
                  ld_addr_q <= ld_addr_q + 4'h1;
                  if (ld_addr_q == fsd_pkg::A_LAST)
                  begin
                     st_q <= ST_IDLE;
                     lock_active_q <= lock_stored_q
                        | (ld_addr_q == fsd_pkg::A_LOCK && nvm_rdata[0]);
                  end
               end
            end
            ST_IDLE:
            begin
               if (cmd_take)
               begin
                  op_addr_q <= cmd_addr;
                  op_wdata_q <= cmd_wdata;
                  op_write_q <= cmd_write && wr_allowed;
                  op_ok_q <= !cmd_write || wr_allowed;
                  // memory touched only for storable addresses
                  if ((cmd_write && wr_allowed)
                      || (!cmd_write && cmd_addr != fsd_pkg::A_RAW
                          && cmd_addr <= fsd_pkg::A_LAST))
                     st_q <= ST_EXEC;
                  else
                     st_q <= ST_RESP;
               end
            end
            ST_EXEC:
            begin
               if (upd)
                  st_q <= ST_RESP;
            end
            ST_RESP:
            begin
               op_write_q <= 1'b0;
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // load still reads the lock word even after stored state is set
   assign nvm_req = (st_q == ST_LOAD) || (st_q == ST_EXEC);
   assign nvm_we = (st_q == ST_EXEC) && op_write_q;
   assign nvm_addr = (st_q == ST_LOAD) ? ld_addr_q : op_addr_q;
   assign nvm_wdata = op_wdata_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         op_rdata_q <= '0;
      else if (st_q == ST_IDLE && cmd_take && cmd_addr == fsd_pkg::A_RAW)
         op_rdata_q <= {{2{raw_q[13]}}, raw_q};
      else if (st_q == ST_IDLE && cmd_take)
         op_rdata_q <= '0;
      else if (st_q == ST_EXEC && upd && !op_write_q)
         op_rdata_q <= nvm_rdata;
   end

   // response pulse follows the access
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         resp_valid <= 1'b0;
         resp_ok <= 1'b0;
         resp_data <= '0;
      end
      else
      begin
         resp_valid <= (st_q == ST_RESP);
         if (st_q == ST_RESP)
         begin
            resp_ok <= op_ok_q;
            resp_data <= op_rdata_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // signal path
   stream_if #(.W(fsd_pkg::RAW_W)) flt ();
   stream_if #(.W(fsd_pkg::OUT_W)) res ();
   stream_if #(.W(fsd_pkg::OUT_W)) dac ();
   logic loaded;
   logic filt_in_ready;

   assign loaded = (st_q != ST_LOAD);
   assign adc_ready = filt_in_ready && loaded;

   lp_filter u_filter (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .filt_sel(mode_q[fsd_pkg::FILT_LSB +: 3]),
      .in_valid(adc_valid && loaded),
      .in_data(adc_data),
      .in_ready(filt_in_ready),
      .flt(flt.src)
   );

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         raw_q <= '0;
      else if (flt.valid)
         raw_q <= flt.data;
   end

   logic signed [27:0] prod;
   logic signed [SW-1:0] scaled;
   logic signed [SW-1:0] sum;
   logic signed [15:0] sat;
   logic signed [15:0] lim;
   logic res_v_q;
   logic [10:0] res_d_q;

   localparam logic signed [15:0] SAT_HI = 16'h7fff;
   localparam logic signed [15:0] SAT_LO = 16'h8000;

   // sample is signed: north positive, south negative
   assign prod = signed'(flt.data) * signed'(gain_q);
   assign scaled = SW'(prod >>> fsd_pkg::GAIN_FRAC);
   // offset step is two output codes
   assign sum = scaled + (SW'(signed'(ofs_q)) <<< 1);

   always_comb
   begin
      if (sum > SW'(SAT_HI))
         sat = SAT_HI;
      else if (sum < SW'(SAT_LO))
         sat = SAT_LO;
      else
         sat = sum[15:0];
      // clamp low first; a high limit below it wins
      lim = sat;
      if (lim < signed'({6'h00, clo_q}))
         lim = signed'({6'h00, clo_q});
      if (lim > signed'({5'h00, chi_q}))
         lim = signed'({5'h00, chi_q});
   end

   // one register stage; stalls when buffer is full
   assign flt.ready = !res_v_q || res.ready;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         res_v_q <= 1'b0;
         res_d_q <= '0;
      end
      else if (flt.ready)
      begin
         res_v_q <= flt.valid;
         if (flt.valid)
            res_d_q <= lim[10:0];
      end
   end

   assign res.valid = res_v_q;
   assign res.data = res_d_q;

   skid_buffer #(.W(fsd_pkg::OUT_W), .DEPTH(2)) u_buf (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr(res.snk),
      .rd(dac.src)
   );

   assign dac_valid = dac.valid;
   assign dac_data = dac.data;
   assign dac.ready = dac_ready;

   ////////////////////////////////////////////////////////////////////////
   // configuration outputs
   always_comb
   begin
      unique case (mode_q[fsd_pkg::RANGE_LSB +: 3])
         3'h0: adc_range_mt = 8'h1e;
         3'h4: adc_range_mt = 8'h28;
         3'h5: adc_range_mt = 8'h3c;
         3'h1: adc_range_mt = 8'h4b;
         3'h6: adc_range_mt = 8'h50;
         3'h2: adc_range_mt = 8'h5a;
         3'h7: adc_range_mt = 8'h64;
         3'h3: adc_range_mt = 8'h96;
      endcase
   end

   assign adc_range_sel = mode_q[fsd_pkg::RANGE_LSB +: 3];
   assign tc_lin = tc_q;
   assign tc_quad = quadratic_temp_coefficient_q;
   assign lock_active = lock_active_q;
   // pin carries only digital answers while talking
   assign analog_drive_en = loaded && !comm_active && (st_q == ST_IDLE);

endmodule : field_sensor_dsp_chain

// ### bench/fsd_props.sv
`timescale 1ns/1ps
module fsd_props (
   input wire logic ref_clk, // clock
   input wire logic arst_n, // async reset
   input wire logic [2:0] adc_range_sel, // range code
   input wire logic [7:0] adc_range_mt, // range in mT
   input wire logic comm_active, // modulation seen
   input wire logic analog_drive_en, // output stage on
   input wire logic resp_valid, // response pulse
   input wire logic nvm_req, // memory request
   input wire logic nvm_we, // memory write
   input wire logic [3:0] nvm_addr, // memory address
   input wire logic [15:0] nvm_wdata, // memory data
   input wire logic nvm_ack, // memory done
   input wire logic lock_active, // frozen
   input wire logic dac_valid, // code valid
   input wire logic dac_ready, // code taken
   input wire logic [10:0] dac_data // code
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   function automatic logic [7:0] mt_of(input logic [2:0] r);
      case (r)
         3'h0: mt_of = 8'h1e;
         3'h4: mt_of = 8'h28;
         3'h5: mt_of = 8'h3c;
         3'h1: mt_of = 8'h4b;
         3'h6: mt_of = 8'h50;
         3'h2: mt_of = 8'h5a;
         3'h7: mt_of = 8'h64;
         default: mt_of = 8'h96;
      endcase
   endfunction : mt_of

   a_range_decode:
      assert property (adc_range_mt == mt_of(adc_range_sel))
      else $error("range magnitude wrong for code");
   a_resp_pulse:
      assert property (resp_valid |=> !resp_valid)
      else $error("response longer than one cycle");
   a_comm_quiet:
      assert property (comm_active |-> !analog_drive_en)
      else $error("analog drive on during communication");
   a_access_quiet:
      assert property (nvm_req |-> !analog_drive_en)
      else $error("analog drive on during memory access");
   a_lock_silent:
      assert property (lock_active |-> !resp_valid && !nvm_we)
      else $error("locked device answered or wrote");
   a_lock_sticky:
      assert property (lock_active |=> lock_active)
      else $error("lock dropped without reset");
   a_nvm_hold:
      assert property (nvm_req && !nvm_ack |=> nvm_req && $stable(nvm_addr)
         && $stable(nvm_we) && $stable(nvm_wdata))
      else $error("memory request changed before ack");
   a_dac_hold:
      assert property (dac_valid && !dac_ready |=> dac_valid
         && $stable(dac_data))
      else $error("output code lost while stalled");
endmodule : fsd_props

bind field_sensor_dsp_chain fsd_props u_props (.ref_clk(ref_clk),
   .arst_n(arst_n), .adc_range_sel(adc_range_sel),
   .adc_range_mt(adc_range_mt), .comm_active(comm_active),
   .analog_drive_en(analog_drive_en), .resp_valid(resp_valid),
   .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
   .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack), .lock_active(lock_active),
   .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_data(dac_data));

// ### bench/nvm_model.sv
`timescale 1ns/1ps
module nvm_model (
   input wire logic ref_clk, // clock
   input wire logic arst_n, // power-on reset
   input wire logic [1:0] lat, // wait cycles before ack
   input wire logic nvm_req, // access request
   input wire logic nvm_we, // access is write
   input wire logic [3:0] nvm_addr, // word address
   input wire logic [15:0] nvm_wdata, // write data
   output logic nvm_ack, // access done
   output logic [15:0] nvm_rdata // read data
);
   logic [15:0] mem_q [0:11];
   logic [1:0] wait_q;
   // contents survive reset, so a stored lock comes back
   initial
   begin
      mem_q = '{16'h0023, 16'h0011, 16'h0022, 16'h0800, 16'h0100, 16'h0050,
         16'h07ff, 16'h0000, 16'h0000, 16'h1234, 16'h5678, 16'h9abc};
      wait_q = 2'h0;
      nvm_ack = 1'b0;
      nvm_rdata = 16'h0000;
   end
   // idle data toggles so a stale word is never mistaken for an answer
   always @(posedge ref_clk)
   begin
      nvm_ack <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      if (!arst_n)
         wait_q <= 2'h0;
      else if (nvm_req && !nvm_ack && wait_q != lat)
         wait_q <= wait_q + 2'h1;
      else if (nvm_req && !nvm_ack)
      begin
         wait_q <= 2'h0;
         nvm_ack <= 1'b1;
         if (nvm_addr < 4'hc)
         begin
            nvm_rdata <= mem_q[nvm_addr];
            if (nvm_we)
               mem_q[nvm_addr] <= nvm_wdata;
         end
      end
   end
endmodule : nvm_model

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
   logic ref_clk, arst_n, adc_valid, adc_ready, dac_valid, dac_ready;
   logic analog_drive_en, comm_active, sel_pin, cmd_valid, cmd_write;
   logic resp_valid, resp_ok, nvm_req, nvm_we, nvm_ack, lock_active;
   logic [13:0] adc_data;
   logic [2:0] adc_range_sel;
   logic [7:0] adc_range_mt, tc_lin, tc_quad;
   logic [47:0] trim_bus;
   logic [10:0] dac_data, last_out;
   logic [3:0] cmd_addr, nvm_addr;
   logic [15:0] cmd_wdata, resp_data, nvm_wdata, nvm_rdata;
   logic [1:0] lat;
   int bad_count, compares, n_in, n_out, cyc;

   field_sensor_dsp_chain u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
      .adc_valid(adc_valid), .adc_data(adc_data), .adc_ready(adc_ready),
      .adc_range_sel(adc_range_sel), .adc_range_mt(adc_range_mt),
      .tc_lin(tc_lin), .tc_quad(tc_quad), .trim_bus(trim_bus),
      .dac_valid(dac_valid), .dac_data(dac_data), .dac_ready(dac_ready),
      .analog_drive_en(analog_drive_en), .comm_active(comm_active),
      .sel_pin(sel_pin), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
      .resp_ok(resp_ok), .resp_data(resp_data), .nvm_req(nvm_req),
      .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
      .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .lock_active(lock_active));
   nvm_model u_nvm (.ref_clk(ref_clk), .arst_n(arst_n), .lat(lat),
      .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
      .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata));

   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // slow receiver: takes codes 3 cycles in 8, so the buffer fills
   always @(negedge ref_clk)
      dac_ready <= (cyc % 8) < 3;
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (dac_valid && dac_ready)
      begin
         n_out <= n_out + 1;
         last_out <= dac_data;
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] e,
      input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   task automatic timeout(input string what);
      bad_count++;
      $display("BAD %s expected done seen timeout", what);
      end_of_test();
   endtask : timeout

   task automatic power_up;
      int i;
      arst_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      arst_n = 1'b1;
      for (i = 0; i < 400; i++)
      begin
         @(negedge ref_clk);
         if (nvm_req === 1'b0)
            break;
      end
      if (i == 400)
         timeout("parameter load");
   endtask : power_up

   task automatic cmd(input logic w, input logic [3:0] a,
      input logic [15:0] d, input bit exp, input logic e_ok,
      input logic [15:0] e_data, input logic [15:0] m);
      int i;
      bit got;
      got = 1'b0;
      cmd_write = w;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_valid = 1'b1;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      for (i = 0; i < 40 && !got; i++)
      begin
         @(negedge ref_clk);
         got = (resp_valid === 1'b1);
      end
      if (exp && !got)
         timeout("response");
      chk("response seen", {15'h0, exp}, {15'h0, got});
      if (got)
         chk("resp_ok", {15'h0, e_ok}, {15'h0, resp_ok});
      if (got && !w)
         chk("resp_data", e_data & m, resp_data & m);
   endtask : cmd

   task automatic feed(input logic [13:0] x, input int n);
      int i;
      // strobe stays up across samples, so it never toggles within a step
      adc_data = x;
      adc_valid = 1'b1;
      repeat (n)
      begin
         for (i = 0; i < 100; i++)
         begin
            #1;
            if (adc_ready === 1'b1)
               break;
            @(negedge ref_clk);
         end
         if (i == 100)
            timeout("adc_ready");
         @(negedge ref_clk);
         n_in++;
      end
      adc_valid = 1'b0;
      for (i = 0; i < 200 && n_out != n_in; i++)
         @(negedge ref_clk);
      chk("codes out", n_in[15:0], n_out[15:0]);
   endtask : feed
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      {adc_valid, comm_active, cmd_valid, cmd_write} = 4'h0;
      {bad_count, compares, n_in} = '0;
      adc_data = 14'h0000;
      cmd_addr = 4'h0;
      cmd_wdata = 16'h0000;
      sel_pin = 1'b1;
      lat = 2'h0;
      last_out = 11'h000;
      power_up();
      chk("trim_bus lo", 16'h1234, trim_bus[15:0]);
      chk("trim_bus mid", 16'h5678, trim_bus[31:16]);
      chk("trim_bus hi", 16'h9abc, trim_bus[47:32]);
      chk("tc", 16'h1122, {tc_lin, tc_quad});
      chk("range", 16'h0396, {5'h0, adc_range_sel, adc_range_mt});
      $display("test load done");
      lat = 2'h2;
      cmd(0, fsd_pkg::A_GAIN, 0, 1, 1, 16'h0800, 16'hffff);
      cmd(1, fsd_pkg::A_GAIN, 16'h1000, 1, 1, 0, 0);
      cmd(0, fsd_pkg::A_GAIN, 0, 1, 1, 16'h1000, 16'hffff);
      cmd(1, fsd_pkg::A_TRIM0, 16'h0000, 1, 0, 0, 0);
      cmd(0, fsd_pkg::A_TRIM0, 0, 1, 1, 16'h1234, 16'hffff);
      cmd(0, 4'hc, 0, 1, 1, 16'h0000, 16'hffff);
      $display("test commands done");
      feed(14'h1fff, 20);
      cmd(0, fsd_pkg::A_RAW, 0, 1, 1, 16'h05e7, 16'h3fff);
      chk("out at high clamp", 16'h07ff, {5'h0, last_out});
      cmd(1, fsd_pkg::A_CHI, 16'h0600, 1, 1, 0, 0);
      feed(14'h1fff, 20);
      chk("out at new clamp", 16'h0600, {5'h0, last_out});
      feed(14'h2000, 20);
      cmd(0, fsd_pkg::A_RAW, 0, 1, 1, 16'h3a18, 16'h3fff);
      chk("out at low clamp", 16'h0050, {5'h0, last_out});
      cmd(1, fsd_pkg::A_MODE, 16'h000c, 1, 1, 0, 0);
      chk("range new", 16'h0428, {5'h0, adc_range_sel, adc_range_mt});
      $display("test stream done");
      sel_pin = 1'b0;
      repeat (8) @(negedge ref_clk);
      cmd(0, fsd_pkg::A_GAIN, 0, 0, 0, 0, 0);
      sel_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
      comm_active = 1'b1;
      #1 chk("drive in comm", 16'h0, {15'h0, analog_drive_en});
      @(negedge ref_clk);
      comm_active = 1'b0;
      #1 chk("drive idle", 16'h1, {15'h0, analog_drive_en});
      @(negedge ref_clk);
      $display("test select done");
      cmd(1, fsd_pkg::A_LOCK, 16'h0001, 1, 1, 0, 0);
      chk("lock before cycle", 16'h0, {15'h0, lock_active});
      cmd(1, fsd_pkg::A_OFS, 16'h0000, 1, 1, 0, 0);
      power_up();
      chk("lock after cycle", 16'h1, {15'h0, lock_active});
      cmd(1, fsd_pkg::A_LOCK, 16'h0000, 0, 0, 0, 0);
      cmd(0, fsd_pkg::A_GAIN, 0, 0, 0, 0, 0);
      chk("lock kept", 16'h1, {15'h0, lock_active});
      $display("test lock done");
      end_of_test();
   end
endmodule : tb
